// *** bench/sto_monitor_props.sv ***
// Port checker for the torque-off monitor
module stom_monitor_props (
  // Watched ports
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  input wire logic       SAFETY_INPUT_ONE,
  input wire logic       SAFETY_INPUT_TWO,
  input wire logic       MOTOR_RUNNING,
  input wire logic       TORQUE_MODE,
  input wire logic       BASE_ENABLE,
  input wire logic       DYNAMIC_BRAKE,
  input wire logic       DECEL_REQUEST,
  input wire logic       SHUTOFF_MONITOR_ONE,
  input wire logic       SHUTOFF_MONITOR_TWO,
  input wire logic       SHUTOFF_MONITOR_SERIES,
  input wire logic       SHUTOFF_TIMING_ALARM,
  input wire logic [7:0] ALARM_NUMBER
);
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  property p_open; SHUTOFF_MONITOR_ONE || SHUTOFF_MONITOR_TWO |-> !BASE_ENABLE; endproperty
  a_open: assert property (p_open) else $error("drive on, channel open");
  property p_rel; $rose(BASE_ENABLE) |-> $past(SAFETY_INPUT_ONE, 2) && $past(SAFETY_INPUT_TWO, 2); endproperty
  a_rel: assert property (p_rel) else $error("release without both");
  property p_mon1; $fell(SHUTOFF_MONITOR_ONE) |-> $past(SAFETY_INPUT_ONE, 3); endproperty
  a_mon1: assert property (p_mon1) else $error("monitor one opened early");
  property p_mon2; $fell(SHUTOFF_MONITOR_TWO) |-> $past(SAFETY_INPUT_TWO, 3); endproperty
  a_mon2: assert property (p_mon2) else $error("monitor two opened early");
  property p_ser; SHUTOFF_MONITOR_SERIES == (SHUTOFF_MONITOR_ONE || SHUTOFF_MONITOR_TWO); endproperty
  a_ser: assert property (p_ser) else $error("series path wrong");
  property p_alm; $fell(BASE_ENABLE) && $past(MOTOR_RUNNING, 3) |->
    DYNAMIC_BRAKE && SHUTOFF_TIMING_ALARM && ALARM_NUMBER == stom_pkg::ALARM_CODE; endproperty
  a_alm: assert property (p_alm) else $error("no brake or alarm");
  property p_tq; TORQUE_MODE && $past(TORQUE_MODE) |-> !DECEL_REQUEST; endproperty
  a_tq: assert property (p_tq) else $error("decel in torque mode");
  property p_flt; $rose(SHUTOFF_MONITOR_ONE) |-> !$past(SAFETY_INPUT_ONE, 4) && !$past(SAFETY_INPUT_ONE, 8); endproperty
  a_flt: assert property (p_flt) else $error("short open taken");
endmodule
bind stom_monitor stom_monitor_props u_props (.*);

// *** bench/sto_relay.sv ***
// Safety relay model driving both torque-off inputs
module stom_relay (
  // Commands from the bench
  input  wire logic       CORE_CLK,
  input  wire logic [1:0] open_req,
  input  wire logic       pulse,
  // Safety inputs, high while closed
  output logic            ch_one,
  output logic            ch_two
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned pulse_cnt = 0;
  // Test pulse opens both inputs for 1000 cycles only
  always @(posedge CORE_CLK) begin
    if (pulse && pulse_cnt == 0) pulse_cnt <= 1000;
    else if (pulse_cnt != 0) pulse_cnt <= pulse_cnt - 1;
  end
  // Bench also opens channels with the motor running, door interlock assumed
  assign ch_one = !open_req[0] && pulse_cnt == 0;
  assign ch_two = !open_req[1] && pulse_cnt == 0;
endmodule

// *** bench/tb_sto_monitor.sv ***
// Self-checking bench for the torque-off monitor
module tb_safe_torque_off_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 0, RSTN = 0, MOTOR_RUNNING = 0, TORQUE_MODE = 0, ALARM_RESET = 0;
  logic FORCED_STOP_TWO_INPUT = 1, pulse = 0, SAFETY_INPUT_ONE, SAFETY_INPUT_TWO;
  logic BASE_ENABLE, DYNAMIC_BRAKE, DECEL_REQUEST, SHUTOFF_TIMING_ALARM;
  logic SHUTOFF_MONITOR_ONE, SHUTOFF_MONITOR_TWO, SHUTOFF_MONITOR_SERIES;
  logic [7:0] ALARM_NUMBER;
  logic [1:0] open_req = 2'h3;
  int fail_count = 0, comparisons = 0;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("Error %0t: mismatch", $time); end end
  always #20 CORE_CLK = ~CORE_CLK;
  stom_monitor u_dut (.*);
  stom_relay u_relay (.CORE_CLK, .open_req, .pulse, .ch_one(SAFETY_INPUT_ONE),
    .ch_two(SAFETY_INPUT_TWO));
  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task st(input logic be, m1, m2, al);
    `CHK(BASE_ENABLE, be)
    `CHK(SHUTOFF_MONITOR_ONE, m1)
    `CHK(SHUTOFF_MONITOR_TWO, m2)
    `CHK(SHUTOFF_MONITOR_SERIES, m1 | m2)
    `CHK(ALARM_NUMBER, al ? stom_pkg::ALARM_CODE : 8'h00)
    `CHK(SHUTOFF_TIMING_ALARM, al)
  endtask
  task t_release;
    open_req = 2'h0;
    cyc(10);
    st(1, 0, 0, 0);
    $display("release done");
  endtask
  task t_pulse;
    pulse = 1;
    cyc(1);
    pulse = 0;
    cyc(500);
    st(1, 0, 0, 0);
    cyc(600);
    st(1, 0, 0, 0);
    $display("test pulse done");
  endtask
  task t_single(input logic [1:0] m);
    open_req = m;
    cyc(25010);
    st(0, m[0], m[1], 0);
    open_req = 2'h0;
    cyc(10);
    st(1, 0, 0, 0);
    $display("single channel done");
  endtask
  task t_running;
    MOTOR_RUNNING = 1;
    cyc(5);
    open_req = 2'h3;
    cyc(25010);
    st(0, 1, 1, 1);
    `CHK(DYNAMIC_BRAKE, 1'b1)
    MOTOR_RUNNING = 0;
    open_req = 2'h0;
    cyc(10);
    `CHK(DYNAMIC_BRAKE, 1'b0)
    st(0, 0, 0, 1);
    ALARM_RESET = 1;
    cyc(1);
    ALARM_RESET = 0;
    cyc(10);
    st(1, 0, 0, 0);
    $display("running shut-off done");
  endtask
  task t_torque;
    MOTOR_RUNNING = 1;
    FORCED_STOP_TWO_INPUT = 0;
    cyc(10);
    `CHK(DECEL_REQUEST, 1'b1)
    TORQUE_MODE = 1;
    cyc(3);
    `CHK(DECEL_REQUEST, 1'b0)
    TORQUE_MODE = 0;
    FORCED_STOP_TWO_INPUT = 1;
    MOTOR_RUNNING = 0;
    cyc(5);
    `CHK(DECEL_REQUEST, 1'b0)
    $display("torque mode done");
  endtask
  task end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(100000);
    fail_count++;
    end_sim;
  end
  initial begin
    cyc(8);
    RSTN = 1;
    cyc(2);
    st(0, 1, 1, 0);
    t_release;
    t_pulse;
    t_single(2'h1);
    t_single(2'h2);
    t_running;
    t_torque;
    end_sim;
  end
endmodule

// *** hdl/sto_chan_if.sv ***
// Carrier between the top module and each input channel filter
interface stom_chan_if;
  logic raw_closed;
  logic closed;
  modport filt (input raw_closed, output closed);
  modport top (output raw_closed, input closed);
endinterface

// *** hdl/sto_filter.sv ***
// One safety input channel: synchroniser and test-pulse filter
module stom_filter (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Channel
  stom_chan_if.filt ch
);
  logic                        sync_a;
  logic                        sync_b;
  logic [stom_pkg::FILT_W-1:0] open_cnt;
  logic                        closed;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= ch.raw_closed; // R13
      sync_b <= sync_a;
    end
  end

  // Open longer than a test pulse counts as shut-off
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      open_cnt <= '0;
      closed   <= 1'b0;
    end else if (sync_b) begin
      open_cnt <= '0;
      closed   <= 1'b1;
    end else if (open_cnt >= stom_pkg::FILT_LIMIT) begin
      closed   <= 1'b0; // R13
    end else begin
      open_cnt <= open_cnt + 1'b1;
    end
  end

  assign ch.closed = closed;
endmodule

// *** hdl/sto_monitor.sv ***
// Dual-channel torque-off input logic with monitor outputs and timing alarm
// How it works
// R1: First input open puts the amplifier into base shut-off.
// R2: Second input open also forces base shut-off, independently.
// R3: Drive is released only when both inputs are closed.
// R4: First monitor closes while first input is open, opens otherwise.
// R5: Second monitor closes while second input is open, opens otherwise.
// R6: Path between monitors conducts if either input is open.
// R7: Controller test pulses keep inputs open at most 1 ms.
// R8: Controller opens both inputs together, never one alone.
// R9: Controller opens inputs only after the motor has stopped.
// R10: Shut-off while running gives dynamic-brake stop and alarm 63.
// R11: External interlock opens the door only after motor stop.
// R12: Torque mode offers no forced stop deceleration.
// R13: Inputs synchronised; opens up to test-pulse width are ignored.
module stom_monitor (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  // Safety inputs, high while closed to the common
  input  wire logic       SAFETY_INPUT_ONE,
  input  wire logic       SAFETY_INPUT_TWO,
  // Drive status from the amplifier core
  input  wire logic       MOTOR_RUNNING,
  input  wire logic       TORQUE_MODE,
  input  wire logic       FORCED_STOP_TWO_INPUT,
  input  wire logic       ALARM_RESET,
  // Power stage control
  output logic            BASE_ENABLE,
  output logic            DYNAMIC_BRAKE,
  output logic            DECEL_REQUEST,
  // Monitor contacts, high while closed
  output logic            SHUTOFF_MONITOR_ONE,
  output logic            SHUTOFF_MONITOR_TWO,
  output logic            SHUTOFF_MONITOR_SERIES,
  // Alarm
  output logic            SHUTOFF_TIMING_ALARM,
  output logic [7:0]      ALARM_NUMBER
);
  // Channel carriers, index 0 for the first input
  stom_chan_if           ch [2] ();
  logic [1:0]            raw_closed;
  logic [1:0]            chan_closed;
  logic                  both_closed;
  logic                  run_sync_a;
  logic                  run_sync_b;
  logic                  fs2_sync_a;
  logic                  fs2_sync_b;
  logic                  enter_brake;
  stom_pkg::stom_state_t state;
  stom_pkg::stom_state_t next_state;

  // Drive power is on only in the run state
  function automatic logic is_run(input stom_pkg::stom_state_t s);
    return s == stom_pkg::S_RUN;
  endfunction

  function automatic logic is_brake(input stom_pkg::stom_state_t s);
    return s == stom_pkg::S_BRAKE;
  endfunction

  assign raw_closed = {SAFETY_INPUT_TWO, SAFETY_INPUT_ONE};

  // One synchroniser and test-pulse filter per channel
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign ch[i].raw_closed = raw_closed[i];
    assign chan_closed[i]   = ch[i].closed;

    stom_filter u_filt (
      .CORE_CLK (CORE_CLK),
      .RSTN     (RSTN),
      .ch       (ch[i])
    );
  end

  // Motor status comes from another part of the drive
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      run_sync_a <= 1'b0;
      run_sync_b <= 1'b0;
    end else begin
      run_sync_a <= MOTOR_RUNNING;
      run_sync_b <= run_sync_a;
    end
  end

  // Forced stop input is a pin
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      fs2_sync_a <= 1'b0;
      fs2_sync_b <= 1'b0;
    end else begin
      fs2_sync_a <= FORCED_STOP_TWO_INPUT;
      fs2_sync_b <= fs2_sync_a;
    end
  end

  assign both_closed = chan_closed[0] & chan_closed[1]; // R3

  // Shut-off while running means a brake stop first
  always_comb begin
    next_state = state;
    unique case (state)
      stom_pkg::S_RUN: begin
        if (!both_closed) begin // R1 R2
          next_state = run_sync_b ? stom_pkg::S_BRAKE : stom_pkg::S_OFF; // R10
        end
      end
      stom_pkg::S_BRAKE: begin
        if (!run_sync_b) begin
          next_state = stom_pkg::S_OFF;
        end
      end
      stom_pkg::S_OFF: begin
        if (both_closed && !SHUTOFF_TIMING_ALARM) begin // R3
          next_state = stom_pkg::S_RUN;
        end
      end
      default: next_state = stom_pkg::S_OFF;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      state <= stom_pkg::S_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign enter_brake = is_run(state) && is_brake(next_state); // R10

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      BASE_ENABLE <= 1'b0;
    end else begin
      BASE_ENABLE <= is_run(next_state); // R1 R2 R3
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      DYNAMIC_BRAKE <= 1'b0;
    end else begin
      DYNAMIC_BRAKE <= is_brake(next_state); // R10
    end
  end

  // Forced stop deceleration, unavailable in torque mode
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      DECEL_REQUEST <= 1'b0;
    end else begin
      DECEL_REQUEST <= !fs2_sync_b && !TORQUE_MODE && run_sync_b
                       && is_run(next_state); // R12
    end
  end

  // Monitor contacts are closed while the channel is open
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      SHUTOFF_MONITOR_ONE <= 1'b1;
    end else begin
      SHUTOFF_MONITOR_ONE <= !chan_closed[0]; // R4
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      SHUTOFF_MONITOR_TWO <= 1'b1;
    end else begin
      SHUTOFF_MONITOR_TWO <= !chan_closed[1]; // R5
    end
  end

  // Series path conducts while either filtered channel is open
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      SHUTOFF_MONITOR_SERIES <= 1'b1;
    end else begin
      SHUTOFF_MONITOR_SERIES <= !both_closed; // R6
    end
  end

  // Alarm sticks until reset request; a new event wins over the clear
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      SHUTOFF_TIMING_ALARM <= 1'b0;
    end else if (enter_brake) begin
      SHUTOFF_TIMING_ALARM <= 1'b1; // R10
    end else if (ALARM_RESET) begin
      SHUTOFF_TIMING_ALARM <= 1'b0;
    end
  end

  // Number follows the flag with the same priority
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ALARM_NUMBER <= 8'h00;
    end else if (enter_brake) begin
      ALARM_NUMBER <= stom_pkg::ALARM_CODE; // R10
    end else if (ALARM_RESET) begin
      ALARM_NUMBER <= 8'h00;
    end
  end

endmodule

// *** hdl/sto_pkg.sv ***
// Constants and types for the torque-off monitor block
package stom_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned TEST_PULSE_US   = 1000;
  // Longest test pulse in cycles, rounded down
  localparam int unsigned TEST_PULSE_CYC  = (CLK_HZ / 1_000_000) * TEST_PULSE_US;
  localparam int unsigned FILT_W          = 16;
  localparam logic [7:0]  ALARM_CODE      = 8'h63;
  localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(TEST_PULSE_CYC);

  typedef enum logic [1:0] {
    S_RUN   = 2'b00,
    S_BRAKE = 2'b01,
    S_OFF   = 2'b11
  } stom_state_t;
endpackage
